// >>> bench/latched_status_interrupt_unit_test.sv
`timescale 1ns/1ns
`default_nettype none
module latched_status_interrupt_unit_test;
  import lsiu_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_out;
  lsiu_bank_t  cond_in = '0;
  lsiu_bank_t  evt_in = '0;
  lsiu_byte_t  sync_in = 8'h00;
  int          fail_count = 0;
  int          comparisons = 0;
  logic [31:0] rd;
  always #25 pclk = ~pclk;
  lsiu_cport_if cp_if ();
  lsiu_device lsiu_device_inst (.pclk(pclk), .presetn(presetn), .cp(cp_if),
    .cond_in(cond_in), .evt_in(evt_in), .sync_in(sync_in));
  lsiu_host lsiu_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_out(irq_out), .cp(cp_if));
  lsiu_sva lsiu_sva_inst (.pclk(pclk), .presetn(presetn), .cp_addr(cp_if.cp_addr),
    .cp_wdata(cp_if.cp_wdata), .cp_wr(cp_if.cp_wr), .cp_rd(cp_if.cp_rd),
    .cp_rdata(cp_if.cp_rdata), .cp_rvalid(cp_if.cp_rvalid), .cp_int(cp_if.cp_int));
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; waits on pready with a bound
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
    int i;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // issue a command, then poll busy until it drops
  task automatic cmd(lsiu_op_t op, logic [7:0] a, logic [7:0] d);
    int i;
    apb(LSIU_APB_CMD, 1'b1, {14'h0000, op, d, a});
    i = 0;
    do begin
      apb(LSIU_APB_STAT, 1'b0, 32'h0000_0000);
      i++;
    end while (rd[LSIU_ST_BUSY] !== 1'b0 && i < 20);
    if (rd[LSIU_ST_BUSY] !== 1'b0) begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic sel(int k, logic [7:0] s, logic [7:0] e);
    cmd(LSIU_OP_SELRD, LSIU_OFS_STAT[k], s);
    check("status copy", rd[15:8], e);
  endtask
  task automatic rdb(logic [7:0] a, logic [7:0] e);
    cmd(LSIU_OP_READ, a, 8'h00);
    check("read byte", rd[15:8], e);
  endtask
  task automatic irq(logic e);
    tick(4);
    check("irq_out", {7'h00, irq_out}, {7'h00, e});
    apb(LSIU_APB_STAT, 1'b0, 32'h0000_0000);
    check("status irq", {7'h00, rd[LSIU_ST_IRQ]}, {7'h00, e});
  endtask
  task automatic t_reset();
    apb(LSIU_APB_STAT, 1'b0, 32'h0000_0000);
    check("status word", rd[7:0], 8'h00);
    irq(1'b0);
    rdb(LSIU_OFS_SUMMARY, 8'h00);
    rdb(LSIU_OFS_MASK[0], 8'h00);
  endtask
  task automatic t_event();
    evt_in[0][5] <= 1'b1;
    tick(1);
    evt_in[0][5] <= 1'b0;
    irq(1'b0);
    cmd(LSIU_OP_WRITE, LSIU_OFS_MASK[0], 8'h20);
    rdb(LSIU_OFS_MASK[0], 8'h20);
    irq(1'b1);
    rdb(LSIU_OFS_SUMMARY, 8'h01);
    sel(0, 8'h20, 8'h20);
    irq(1'b0);
    sel(0, 8'h20, 8'h00);
  endtask
  // partial select keeps other copy bits; mask quiets pin
  task automatic t_hold();
    evt_in[2][4] <= 1'b1;
    evt_in[2][6] <= 1'b1;
    tick(1);
    evt_in[2] <= 8'h00;
    cmd(LSIU_OP_WRITE, LSIU_OFS_MASK[2], 8'hFF);
    irq(1'b1);
    cmd(LSIU_OP_WRITE, LSIU_OFS_MASK[2], 8'h00);
    irq(1'b0);
    cmd(LSIU_OP_WRITE, LSIU_OFS_MASK[2], 8'hFF);
    irq(1'b1);
    sel(2, 8'h10, 8'h10);
    rdb(LSIU_OFS_SUMMARY, 8'h04);
    sel(2, 8'h40, 8'h50);
    sel(2, 8'hFF, 8'h00);
  endtask
  // condition persists, paired event on clearing
  task automatic t_cond();
    cond_in[1][0] <= 1'b1;
    tick(2);
    sel(1, 8'h01, 8'h01);
    sel(1, 8'h01, 8'h01);
    cond_in[1][0] <= 1'b0;
    tick(4);
    sel(1, 8'h11, 8'h11);
    sel(1, 8'h11, 8'h00);
  endtask
  // live info, ignored writes, double bit
  task automatic t_misc();
    int   i;
    logic hit;
    sync_in <= 8'hA5;
    tick(2);
    rdb(LSIU_OFS_SYNC_REALTIME_INFO, 8'hA5);
    sync_in <= 8'h5A;
    irq(1'b0);
    cmd(LSIU_OP_WRITE, LSIU_OFS_SUMMARY, 8'hFF);
    cmd(LSIU_OP_WRITE, LSIU_OFS_SYNC_REALTIME_INFO, 8'h00);
    check("pslverr", {7'h00, pslverr}, 8'h00);
    rdb(LSIU_OFS_SUMMARY, 8'h00);
    rdb(LSIU_OFS_SYNC_REALTIME_INFO, 8'h5A);
    cmd(LSIU_OP_WRITE, LSIU_OFS_MASK[3], 8'h01);
    cond_in[3] <= 8'h03;
    irq(1'b1);
    rdb(LSIU_OFS_SUMMARY, 8'h08);
    // both conditions end on the select edge; only the double bit re-arms
    fork
      sel(3, 8'h03, 8'h03);
      begin
        hit = 1'b0;
        i = 0;
        while (!hit && i < 50) begin
          @(posedge pclk);
          hit = psel && penable && pwrite && (pready === 1'b1);
          i++;
        end
        cond_in[3] <= 8'h00;
      end
    join
    if (!hit) begin
      fail_count++;
      end_sim();
    end
    irq(1'b1);
    sel(3, 8'h03, 8'h01);
    irq(1'b0);
  endtask
  // mid-run reset drops latches, masks and pin
  task automatic t_rerun();
    evt_in[2][4] <= 1'b1;
    tick(1);
    evt_in[2][4] <= 1'b0;
    irq(1'b1);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(2);
    irq(1'b0);
    rdb(LSIU_OFS_MASK[2], 8'h00);
    sel(2, 8'h10, 8'h00);
  endtask
  initial begin
    tick(2);
    presetn <= 1'b1;
    tick(2);
    t_reset();
    t_event();
    t_hold();
    t_cond();
    t_misc();
    t_rerun();
    end_sim();
  end
  // hang guard
  initial begin
    tick(20000);
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire

// >>> bench/lsiu_sva.sv
`timescale 1ns/1ns
`default_nettype none
module lsiu_sva
  import lsiu_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [7:0] cp_addr,
  input wire logic [7:0] cp_wdata,
  input wire logic       cp_wr,
  input wire logic       cp_rd,
  input wire logic [7:0] cp_rdata,
  input wire logic       cp_rvalid,
  input wire logic       cp_int
);
  logic [3:0] mnz_r;
  logic [3:0] mnz_nxt;
  logic       stat_sel;
  // shadow of which masks hold a one, seen from port writes
  always_comb begin
    mnz_nxt = mnz_r;
    for (int k = 0; k < LSIU_NREG; k++) begin
      if (cp_wr && cp_addr == LSIU_OFS_MASK[k]) begin
        mnz_nxt[k] = (cp_wdata != 8'h00);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mnz_r <= 4'h0;
    end else begin
      mnz_r <= mnz_nxt;
    end
  end
  // any of the four status offsets
  assign stat_sel = cp_addr == LSIU_OFS_STAT[0] || cp_addr == LSIU_OFS_STAT[1]
                 || cp_addr == LSIU_OFS_STAT[2] || cp_addr == LSIU_OFS_STAT[3];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // int flop lags a mask change by one edge, so three quiet samples
  sequence s_quiet; (mnz_r == 4'h0) [*3]; endsequence
  sequence s_sel_wr; cp_wr && stat_sel; endsequence
  sequence s_same_rd; cp_rd && cp_addr == $past(cp_addr); endsequence
  property p_masked; s_quiet |-> !cp_int; endproperty
  property p_sel_rd; s_sel_wr |=> s_same_rd; endproperty
  property p_answer; cp_rd |=> cp_rvalid; endproperty
  property p_no_answer; !cp_rd |=> !cp_rvalid; endproperty
  property p_hold; !cp_rvalid |-> $stable(cp_rdata); endproperty
  property p_summ; cp_rd && cp_addr == LSIU_OFS_SUMMARY |=> cp_rdata[7:4] == 4'h0; endproperty
  property p_wr_pulse; cp_wr |=> !cp_wr; endproperty
  property p_rd_pulse; cp_rd |=> !cp_rd; endproperty
  a_masked: assert property (p_masked)
    else $error("int with all masks clear");
  a_sel_rd: assert property (p_sel_rd)
    else $error("select write not followed by read");
  a_answer: assert property (p_answer)
    else $error("read not answered");
  a_no_answer: assert property (p_no_answer)
    else $error("answer without read");
  a_hold: assert property (p_hold)
    else $error("read byte moved between reads");
  a_summ: assert property (p_summ)
    else $error("summary upper bits set");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe too long");
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe too long");
endmodule
`default_nettype wire

// >>> verilog/lsiu_cport_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lsiu_cport_if;
  import lsiu_pkg::*;
  logic [7:0] cp_addr;
  logic [7:0] cp_wdata;
  logic       cp_wr;
  logic       cp_rd;
  logic [7:0] cp_rdata;
  logic       cp_rvalid;
  logic       cp_int;
  modport device (
    input  cp_addr, cp_wdata, cp_wr, cp_rd,
    output cp_rdata, cp_rvalid, cp_int
  );
  modport host (
    output cp_addr, cp_wdata, cp_wr, cp_rd,
    input  cp_rdata, cp_rvalid, cp_int
  );
endinterface
`default_nettype wire

// >>> verilog/lsiu_device.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module lsiu_device #(
  parameter lsiu_pkg::lsiu_bank_t COND_BITS = 32'h0F0F_0F0F,
  parameter lsiu_pkg::lsiu_bank_t DBL_BITS  = 32'h0100_0000,
  parameter lsiu_pkg::lsiu_bank_t PAIR_BITS = 32'h0000_1000
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  lsiu_cport_if.device              cp,
  input  wire lsiu_pkg::lsiu_bank_t cond_in,
  input  wire lsiu_pkg::lsiu_bank_t evt_in,
  input  wire lsiu_pkg::lsiu_byte_t sync_in
);
  import lsiu_pkg::*;

  lsiu_bank_t             lat_r;
  lsiu_bank_t             lat_nxt;
  lsiu_bank_t             copy_r;
  lsiu_bank_t             copy_nxt;
  lsiu_bank_t             mask_r;
  lsiu_bank_t             mask_nxt;
  lsiu_bank_t             cond_q_r;
  lsiu_bank_t             cond_q_nxt;
  lsiu_bank_t             sel;
  lsiu_bank_t             set;
  lsiu_bank_t             fell;
  logic [LSIU_SUMM_W-1:0] summ;
  logic [LSIU_SUMM_W-1:0] summ_r;
  logic [LSIU_SUMM_W-1:0] summ_nxt;
  lsiu_byte_t             rdata_r;
  lsiu_byte_t             rdata_nxt;
  logic                   rvalid_r;
  logic                   rvalid_nxt;
  logic                   int_r;
  logic                   int_nxt;

  // outputs straight from flops
  assign cp.cp_rdata  = rdata_r;
  assign cp.cp_rvalid = rvalid_r;
  assign cp.cp_int    = int_r;

  // per-bit set sources: level, pulse, edges
  always_comb begin
    sel  = '0;
    set  = '0;
    fell = cond_q_r & ~cond_in;
    for (int k = 0; k < LSIU_NREG; k++) begin
      // select byte arrives as a write
      if (cp.cp_wr && (cp.cp_addr == LSIU_OFS_STAT[k])) begin
        sel[k] = cp.cp_wdata;
      end
      for (int b = 0; b < LSIU_DW; b++) begin
        if (COND_BITS[k][b]) begin
          set[k][b] = cond_in[k][b];
          if (DBL_BITS[k][b] && fell[k][b]) begin
            set[k][b] = 1'b1;
          end
        end else begin
          set[k][b] = evt_in[k][b];
        end
      end
      for (int b = 4; b < LSIU_DW; b++) begin
        if (PAIR_BITS[k][b] && !COND_BITS[k][b] && fell[k][b-4]) begin
          set[k][b] = 1'b1;
        end
      end
    end
  end

  // latch and readable copy next values
  always_comb begin
    lat_nxt    = lat_r;
    copy_nxt   = copy_r;
    cond_q_nxt = cond_in;
    for (int k = 0; k < LSIU_NREG; k++) begin
      // latch until read; set wins clear
      // a same-cycle event beats the clear, so none is lost
      lat_nxt[k] = (lat_r[k] & ~sel[k]) | set[k];
      copy_nxt[k] = (copy_r[k] & ~sel[k]) | ((lat_r[k] | set[k]) & sel[k]);
    end
  end

  // status registers; the copy is what the host reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_r    <= '0;
      copy_r   <= '0;
      // edge history starts low, so a condition present
      // at release raises its bit but never a false clear
      cond_q_r <= '0;
    end else begin
      lat_r    <= lat_nxt;
      copy_r   <= copy_nxt;
      cond_q_r <= cond_q_nxt;
    end
  end

  // mask next values; only host writes change them
  always_comb begin
    mask_nxt = mask_r;
    for (int k = 0; k < LSIU_NREG; k++) begin
      // each status register has its own mask
      if (cp.cp_wr && (cp.cp_addr == LSIU_OFS_MASK[k])) begin
        mask_nxt[k] = cp.cp_wdata;
      end
    end
  end

  // mask registers; kept apart so status bursts never touch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '0;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // interrupt aggregation; info bits never enter
  always_comb begin
    for (int k = 0; k < LSIU_NREG; k++) begin
      summ[k] = |(lat_r[k] & mask_r[k]);
    end
    summ_nxt = summ;
    int_nxt  = |summ;
  end

  // summary and pin registers; a flop on the pin keeps
  // decode glitches off the host's interrupt input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // pin low until a mask is set
      summ_r <= '0;
      int_r  <= 1'b0;
    end else begin
      // summary trails the latch by one clock
      summ_r <= summ_nxt;
      int_r  <= int_nxt;
    end
  end

  // read path; one cycle from strobe to data
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (cp.cp_rd) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = LSIU_RST_BYTE;
      if (cp.cp_addr == LSIU_OFS_SUMMARY) begin
        rdata_nxt = {4'h0, summ_r};
      end
      if (cp.cp_addr == LSIU_OFS_SYNC_REALTIME_INFO) begin
        rdata_nxt = sync_in;
      end
      for (int k = 0; k < LSIU_NREG; k++) begin
        if (cp.cp_addr == LSIU_OFS_STAT[k]) begin
          // copy made by the write just before
          rdata_nxt = copy_r[k];
        end
        if (cp.cp_addr == LSIU_OFS_MASK[k]) begin
          rdata_nxt = mask_r[k];
        end
      end
    end
  end

  // read answer registers; data holds until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // no answer pending out of reset
      rdata_r  <= LSIU_RST_BYTE;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/lsiu_host.sv
`timescale 1ns/1ns
`default_nettype none
module lsiu_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_out,
  lsiu_cport_if.host       cp
);
  import lsiu_pkg::*;

  lsiu_hst_t   st_r;
  lsiu_hst_t   st_nxt;
  lsiu_op_t    op_r;
  lsiu_op_t    op_nxt;
  logic [7:0]  addr_r;
  logic [7:0]  addr_nxt;
  logic [7:0]  wdata_r;
  logic [7:0]  wdata_nxt;
  logic [7:0]  res_r;
  logic [7:0]  res_nxt;
  logic        wr_r;
  logic        wr_nxt;
  logic        rd_r;
  logic        rd_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        irq_r;
  logic        pslverr_r;
  logic        apb_wr;

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign irq_out    = irq_r;
  assign cp.cp_addr = addr_r;
  assign cp.cp_wdata = wdata_r;
  assign cp.cp_wr   = wr_r;
  assign cp.cp_rd   = rd_r;
  // zero-wait slave: access phase always completes
  assign apb_wr     = psel && penable && pwrite && pready_r;

  // sequencer; commands while busy are dropped
  always_comb begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    res_nxt   = res_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    case (st_r)
      LSIU_HS_IDLE: begin
        if (apb_wr && (paddr == LSIU_APB_CMD)) begin
          op_nxt    = lsiu_op_t'(pwdata[LSIU_CMD_OP_LSB +: 2]);
          addr_nxt  = pwdata[LSIU_CMD_ADDR_LSB +: 8];
          wdata_nxt = pwdata[LSIU_CMD_DATA_LSB +: 8];
          if (op_nxt == LSIU_OP_READ) begin
            rd_nxt = 1'b1;
            st_nxt = LSIU_HS_RD;
          end else if (op_nxt != LSIU_OP_NONE) begin
            wr_nxt = 1'b1;
            st_nxt = LSIU_HS_WR;
          end
        end
      end
      LSIU_HS_WR: begin
        // select write, read follows at once
        if (op_r == LSIU_OP_SELRD) begin
          rd_nxt = 1'b1;
          st_nxt = LSIU_HS_RD;
        end else begin
          st_nxt = LSIU_HS_IDLE;
        end
      end
      LSIU_HS_RD: begin
        st_nxt = LSIU_HS_WAIT;
      end
      LSIU_HS_WAIT: begin
        if (cp.cp_rvalid) begin
          res_nxt = cp.cp_rdata;
          st_nxt  = LSIU_HS_IDLE;
        end
      end
      default: begin
        st_nxt = LSIU_HS_IDLE;
      end
    endcase
  end

  // read data prepared in the setup phase
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      prdata_nxt = LSIU_APB_RST;
      if (paddr == LSIU_APB_STAT) begin
        prdata_nxt[LSIU_ST_BUSY]           = (st_r != LSIU_HS_IDLE);
        prdata_nxt[LSIU_ST_IRQ]            = irq_r;
        prdata_nxt[LSIU_ST_RDATA_LSB +: 8] = res_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= LSIU_HS_IDLE;
      op_r     <= LSIU_OP_NONE;
      addr_r   <= 8'h00;
      wdata_r  <= 8'h00;
      res_r    <= 8'h00;
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
      prdata_r <= LSIU_APB_RST;
      pready_r <= 1'b0;
      irq_r    <= 1'b0;
      // every transfer completes cleanly; no error source
      pslverr_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      op_r     <= op_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      res_r    <= res_nxt;
      wr_r     <= wr_nxt;
      rd_r     <= rd_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= 1'b1;
      irq_r    <= cp.cp_int;
      pslverr_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/lsiu_pkg.sv
`default_nettype none
package lsiu_pkg;
  // control port geometry
  localparam int          LSIU_NREG     = 4;
  localparam int          LSIU_DW       = 8;
  localparam logic [7:0]  LSIU_RST_BYTE = 8'h00;
  typedef logic [7:0] lsiu_byte_t;
  typedef logic [3:0][7:0] lsiu_bank_t;
  // device register map on the control port
  localparam logic [7:0]  LSIU_OFS_SUMMARY = 8'h13;
  localparam logic [7:0]  LSIU_OFS_SYNC_REALTIME_INFO   = 8'h12;
  localparam logic [7:0]  LSIU_OFS_STAT [LSIU_NREG] = '{8'h14, 8'h16, 8'h18, 8'h1A};
  localparam logic [7:0]  LSIU_OFS_MASK [LSIU_NREG] = '{8'h15, 8'h17, 8'h19, 8'h1B};
  localparam int          LSIU_SUMM_W   = 4;
  // host-side APB map
  localparam logic [7:0]  LSIU_APB_CMD  = 8'h00;
  localparam logic [7:0]  LSIU_APB_STAT = 8'h04;
  localparam int          LSIU_CMD_ADDR_LSB = 0;
  localparam int          LSIU_CMD_DATA_LSB = 8;
  localparam int          LSIU_CMD_OP_LSB   = 16;
  localparam int          LSIU_ST_BUSY      = 0;
  localparam int          LSIU_ST_IRQ       = 1;
  localparam int          LSIU_ST_RDATA_LSB = 8;
  localparam logic [31:0] LSIU_APB_RST      = 32'h0000_0000;
  // host command codes
  typedef enum logic [1:0] {
    LSIU_OP_NONE   = 2'h0,
    LSIU_OP_WRITE  = 2'h1,
    LSIU_OP_READ   = 2'h2,
    LSIU_OP_SELRD  = 2'h3
  } lsiu_op_t;
  // host sequencer states
  typedef enum logic [3:0] {
    LSIU_HS_IDLE = 4'b0001,
    LSIU_HS_WR   = 4'b0010,
    LSIU_HS_RD   = 4'b0100,
    LSIU_HS_WAIT = 4'b1000
  } lsiu_hst_t;
endpackage
`default_nettype wire
